// File: rtl/bscl_loader.sv
// Boot strap decode, SPI flash configuration loader and power switch gating
//
// Notes on behaviour
// - Address strap ratio maps to address bits 3:1, 001b low band, 010b mid band.
// - Boot fetches patch and configuration data from external flash over SPI.
// - SPI clock to flash runs at 10 MHz, below the 12 MHz target; flash must accept it.
// - Flash chip select is low to select, high otherwise.
// - First data bit appears in the same cycle chip select goes active.
// - Outgoing data changes on falling edge; incoming data sampled on rising edge.
// - Serial clock stays low whenever no transfer is in progress.
// - Boot initialises registers, then loads bundles, before normal operation starts.
// - Data-in strapped high: ratio bands choose dead-battery mode, safe or infinite wait.
// - Data-in strapped low: ratio bands choose mode and configuration 1 to 5, infinite wait or reserved.
// - No-response mode enables no switch and waits for main supply.
// - Wait-for-supply modes close sink path, then stall loading until main supply.
// - Retry modes close sink path and retry loading without limit.
// - No-wait mode loads on VBUS, closes switch only as the loaded or fallback configuration says.
// - External modes use pin 16 sink gate; internal modes use first HV path.
// - Loading is attempted on main supply in all modes, on VBUS only in retry and no-wait modes.
// - Strapped fallback applies only when no configuration could be loaded.
// - Safe fallback disables ports; on VBUS acts only as a legacy sink.
// - Infinite-wait fallback stays in boot until configuration arrives.
// - Fallback configs 1 to 5 select documented source and sink roles.
// - Core runs from fast oscillator normally, slow oscillator in low power.
// - Address byte is 0100, three decoded bits, then read/write bit.
`timescale 1ns/10ps
module bscl_loader #(
  parameter int unsigned LOAD_BYTES = 16,
  parameter int unsigned MAX_TRIES = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Strap inputs (digitised ratios, hundredths)
  input wire logic [7:0] address_strap_input,
  input wire logic [7:0] boot_strap_input,
  input wire logic strap_valid,
  // Power status
  input wire logic main_supply_input,
  input wire logic vbus_present,
  input wire logic low_power_req,
  // SPI flash pins
  input wire logic flash_data_in,
  output logic flash_data_out,
  output logic flash_clk,
  output logic flash_cs_n,
  // Loaded data stream
  output logic [7:0] load_data,
  output logic load_valid,
  // Load result from flash: first byte must be neither 00h nor FFh to count as valid
  output logic boot_done,
  output logic cfg_loaded,
  // Strap decode results
  output logic [7:0] unique_address,
  output bscl_pkg::bscl_db_t db_mode,
  output bscl_pkg::bscl_cfg_t fallback_cfg,
  output bscl_pkg::bscl_cfg_t active_cfg,
  // Power switch and port controls
  output logic high_voltage_path_first,
  output logic external_sink_gate_pin,
  output logic ports_enable,
  output logic legacy_sink_only,
  output logic slow_clock_select
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers for pins (three stages, second and third agree)
  logic [2:0] miso_sync_reg;
  logic [2:0] supply_sync_reg;
  logic miso_filt_reg;
  logic supply_filt_reg;

  // Shift pins into synchronisers and filter on agreement
  always_ff @(posedge clock) begin
    miso_sync_reg <= {miso_sync_reg[1:0], flash_data_in};
    supply_sync_reg <= {supply_sync_reg[1:0], main_supply_input};
    if (miso_sync_reg[2] == miso_sync_reg[1]) miso_filt_reg <= miso_sync_reg[2];
    if (supply_sync_reg[2] == supply_sync_reg[1]) supply_filt_reg <= supply_sync_reg[2];
  end

  ////////////////////////////////////////////////////////////////////////
  // Strap decode
  wire [7:0] ar = address_strap_input;
  wire [7:0] br = boot_strap_input;
  wire [2:0] addr_dec = (ar < bscl_pkg::T19) ? bscl_pkg::ADDR_GND :
                        (ar < bscl_pkg::T39) ? bscl_pkg::ADDR_LOW :
                        (ar < bscl_pkg::T59) ? bscl_pkg::ADDR_MID :
                        bscl_pkg::ADDR_HIGH;
  wire [2:0] band = (br < bscl_pkg::T19) ? 3'h0 :
                    (br < bscl_pkg::T29) ? 3'h1 :
                    (br < bscl_pkg::T39) ? 3'h2 :
                    (br < bscl_pkg::T49) ? 3'h3 :
                    (br < bscl_pkg::T59) ? 3'h4 :
                    (br < bscl_pkg::T69) ? 3'h5 :
                    (br < bscl_pkg::T89) ? 3'h6 : 3'h7;
  bscl_pkg::bscl_db_t db_dec;
  bscl_pkg::bscl_cfg_t cfg_dec;

  // Ratio band to mode and fallback configuration
  always_comb begin
    db_dec = bscl_pkg::BSCL_DB_NO_RESPONSE;
    cfg_dec = bscl_pkg::BSCL_CFG_SAFE;
    if (miso_filt_reg) begin
      unique case (band)
        3'h0: begin db_dec = bscl_pkg::BSCL_DB_NO_RESPONSE; end
        3'h1: begin db_dec = bscl_pkg::BSCL_DB_WAIT_INT; end
        3'h2: begin
          db_dec = bscl_pkg::BSCL_DB_RETRY_INT;
          cfg_dec = bscl_pkg::BSCL_CFG_INF_WAIT;
        end
        3'h3: begin db_dec = bscl_pkg::BSCL_DB_WAIT_EXT; end
        3'h4: begin
          db_dec = bscl_pkg::BSCL_DB_RETRY_EXT;
          cfg_dec = bscl_pkg::BSCL_CFG_INF_WAIT;
        end
        default: begin db_dec = bscl_pkg::BSCL_DB_NO_WAIT; end
      endcase
    end else begin
      unique case (band)
        3'h0: begin
          db_dec = bscl_pkg::BSCL_DB_NO_RESPONSE;
          cfg_dec = (br < bscl_pkg::T10) ? bscl_pkg::BSCL_CFG_RESERVED : bscl_pkg::BSCL_CFG_1;
        end
        3'h1: begin
          db_dec = bscl_pkg::BSCL_DB_NO_RESPONSE;
          cfg_dec = bscl_pkg::BSCL_CFG_2;
        end
        3'h2: begin
          db_dec = bscl_pkg::BSCL_DB_RETRY_INT;
          cfg_dec = bscl_pkg::BSCL_CFG_INF_WAIT;
        end
        3'h3: begin
          db_dec = bscl_pkg::BSCL_DB_NO_WAIT;
          cfg_dec = bscl_pkg::BSCL_CFG_3;
        end
        3'h4: begin
          db_dec = bscl_pkg::BSCL_DB_RETRY_EXT;
          cfg_dec = bscl_pkg::BSCL_CFG_INF_WAIT;
        end
        3'h5: begin
          db_dec = bscl_pkg::BSCL_DB_NO_RESPONSE;
          cfg_dec = bscl_pkg::BSCL_CFG_4;
        end
        3'h6: begin
          db_dec = (br < 8'h4F) ? bscl_pkg::BSCL_DB_NO_WAIT : bscl_pkg::BSCL_DB_NO_RESPONSE;
          cfg_dec = bscl_pkg::BSCL_CFG_RESERVED;
        end
        default: begin
          db_dec = bscl_pkg::BSCL_DB_NO_WAIT;
          cfg_dec = bscl_pkg::BSCL_CFG_5;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Boot state machine
  typedef enum logic [2:0] {
    BSCL_S_INIT,
    BSCL_S_STRAP,
    BSCL_S_HOLD,
    BSCL_S_LOAD,
    BSCL_S_CHECK,
    BSCL_S_RUN
  } bscl_state_t;

  bscl_state_t state_reg;
  logic [2:0] addr_reg;
  logic [7:0] tries_reg;
  logic loaded_reg;
  logic [7:0] first_byte_reg;

  // SPI engine registers
  logic [5:0] bit_cnt_reg;
  logic [7:0] byte_cnt_reg;
  logic [31:0] tx_reg;
  logic [7:0] rx_reg;
  logic [3:0] div_reg;
  logic sck_reg;
  logic cs_n_reg;
  logic mosi_reg;
  logic valid_reg;
  logic xfer_done_reg;
  logic frame_end_reg;
  logic [3:0] smp_pipe_reg;
  logic [2:0] rx_bit_reg;
  logic got_first_reg;

  // Loading allowed: wait modes stall until main supply is present
  wire supply_ok = supply_filt_reg;
  wire wait_mode = (db_mode == bscl_pkg::BSCL_DB_WAIT_INT) ||
                   (db_mode == bscl_pkg::BSCL_DB_WAIT_EXT) ||
                   (db_mode == bscl_pkg::BSCL_DB_NO_RESPONSE);
  wire may_load = supply_ok || !wait_mode;
  wire retry_mode = (db_mode == bscl_pkg::BSCL_DB_RETRY_INT) ||
                    (db_mode == bscl_pkg::BSCL_DB_RETRY_EXT) ||
                    (fallback_cfg == bscl_pkg::BSCL_CFG_INF_WAIT);
  wire load_ok = (first_byte_reg != 8'h00) && (first_byte_reg != 8'hFF);
  wire give_up = !retry_mode && (tries_reg >= 8'(MAX_TRIES - 1));

  // Boot sequencing: init, sample straps, wait supply, load, check, run
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= BSCL_S_INIT;
      addr_reg <= 3'h0;
      db_mode <= bscl_pkg::BSCL_DB_NO_RESPONSE;
      fallback_cfg <= bscl_pkg::BSCL_CFG_SAFE;
      tries_reg <= 8'h00;
      loaded_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        BSCL_S_INIT: state_reg <= BSCL_S_STRAP;
        BSCL_S_STRAP: if (strap_valid) begin
          addr_reg <= addr_dec;
          db_mode <= db_dec;
          fallback_cfg <= cfg_dec;
          state_reg <= BSCL_S_HOLD;
        end
        BSCL_S_HOLD: if (may_load) state_reg <= BSCL_S_LOAD;
        BSCL_S_LOAD: if (xfer_done_reg) state_reg <= BSCL_S_CHECK;
        BSCL_S_CHECK: begin
          if (load_ok) begin
            loaded_reg <= 1'b1;
            state_reg <= BSCL_S_RUN;
          end else if (give_up) begin
            state_reg <= BSCL_S_RUN;
          end else begin
            if (tries_reg != 8'hFF) tries_reg <= tries_reg + 8'h01;
            state_reg <= BSCL_S_LOAD;
          end
        end
        BSCL_S_RUN: state_reg <= BSCL_S_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // SPI mode 0 read engine: command, address, then LOAD_BYTES data bytes
  wire start_xfer = (state_reg == BSCL_S_LOAD) && cs_n_reg && !frame_end_reg;
  wire div_hit = (div_reg == bscl_pkg::SCK_HALF - 4'h1);
  wire last_bit = (bit_cnt_reg == 6'h1F) || ((bit_cnt_reg == 6'h07) && (byte_cnt_reg != 8'h00));
  wire in_cmd = (byte_cnt_reg == 8'h00);

  // Clock divider, shifting, chip select
  always_ff @(posedge clock) begin
    if (srst || state_reg != BSCL_S_LOAD) begin
      div_reg <= 4'h0;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
      bit_cnt_reg <= 6'h00;
      byte_cnt_reg <= 8'h00;
      tx_reg <= 32'h0;
      frame_end_reg <= 1'b0;
      xfer_done_reg <= 1'b0;
    end else begin
      xfer_done_reg <= frame_end_reg && (smp_pipe_reg == 4'h0) && !xfer_done_reg;
      if (start_xfer) begin
        cs_n_reg <= 1'b0;
        mosi_reg <= bscl_pkg::FLASH_READ_CMD[7];
        tx_reg <= {bscl_pkg::FLASH_READ_CMD[6:0], bscl_pkg::FLASH_START_ADDR, 1'b0};
        div_reg <= 4'h0;
      end else if (!cs_n_reg) begin
        div_reg <= div_hit ? 4'h0 : div_reg + 4'h1;
        if (div_hit) begin
          sck_reg <= !sck_reg;
          if (sck_reg) begin
            if (last_bit) begin
              bit_cnt_reg <= 6'h00;
              if (byte_cnt_reg == 8'(LOAD_BYTES)) begin
                cs_n_reg <= 1'b1;
                sck_reg <= 1'b0;
                frame_end_reg <= 1'b1;
              end
              byte_cnt_reg <= byte_cnt_reg + 8'h01;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
            mosi_reg <= tx_reg[31];
            tx_reg <= {tx_reg[30:0], 1'b0};
          end
        end
      end
    end
  end

  // Delayed capture: the pin synchroniser lags each rising edge by four core cycles
  wire smp_now = !start_xfer && !cs_n_reg && div_hit && !sck_reg && !in_cmd;
  always_ff @(posedge clock) begin
    if (srst || start_xfer) begin
      smp_pipe_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      got_first_reg <= 1'b0;
      first_byte_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else begin
      smp_pipe_reg <= {smp_pipe_reg[2:0], smp_now};
      valid_reg <= 1'b0;
      if (smp_pipe_reg[3]) begin
        rx_reg <= {rx_reg[6:0], miso_filt_reg};
        rx_bit_reg <= rx_bit_reg + 3'h1;
        if (rx_bit_reg == 3'h7) begin
          valid_reg <= 1'b1;
          got_first_reg <= 1'b1;
          if (!got_first_reg) first_byte_reg <= {rx_reg[6:0], miso_filt_reg};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power gating and outputs
  wire on_vbus = vbus_present && !supply_ok;
  wire ext_mode = (db_mode == bscl_pkg::BSCL_DB_WAIT_EXT) ||
                  (db_mode == bscl_pkg::BSCL_DB_RETRY_EXT);
  wire int_mode = (db_mode == bscl_pkg::BSCL_DB_WAIT_INT) ||
                  (db_mode == bscl_pkg::BSCL_DB_RETRY_INT);
  wire strapped = (state_reg != BSCL_S_INIT) && (state_reg != BSCL_S_STRAP);
  wire running = (state_reg == BSCL_S_RUN);
  wire no_cfg = running && !loaded_reg;
  bscl_pkg::bscl_cfg_t cfg_now;
  assign cfg_now = no_cfg ? fallback_cfg : bscl_pkg::BSCL_CFG_RESERVED;
  wire safe_now = no_cfg && (fallback_cfg == bscl_pkg::BSCL_CFG_SAFE ||
                             fallback_cfg == bscl_pkg::BSCL_CFG_RESERVED);
  wire cfg_sink_ext = no_cfg && (fallback_cfg == bscl_pkg::BSCL_CFG_5);
  wire cfg_sink_int = no_cfg && (fallback_cfg == bscl_pkg::BSCL_CFG_3);
  wire cfg_source = no_cfg && (fallback_cfg == bscl_pkg::BSCL_CFG_1 ||
                    fallback_cfg == bscl_pkg::BSCL_CFG_2 || fallback_cfg == bscl_pkg::BSCL_CFG_4);
  wire hv1_next = (strapped && int_mode) ||
                  (running && loaded_reg) || cfg_sink_int || cfg_source ||
                  (safe_now && on_vbus);
  wire gpio_next = (strapped && ext_mode) || cfg_sink_ext;

  // Registered outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      high_voltage_path_first <= 1'b0;
      external_sink_gate_pin <= 1'b0;
      ports_enable <= 1'b0;
      legacy_sink_only <= 1'b0;
      active_cfg <= bscl_pkg::BSCL_CFG_RESERVED;
      unique_address <= 8'h00;
      boot_done <= 1'b0;
      cfg_loaded <= 1'b0;
      slow_clock_select <= 1'b0;
      flash_clk <= 1'b0;
      flash_cs_n <= 1'b1;
      flash_data_out <= 1'b0;
      load_data <= 8'h00;
      load_valid <= 1'b0;
    end else begin
      high_voltage_path_first <= hv1_next && (db_mode != bscl_pkg::BSCL_DB_NO_RESPONSE
                                 || running);
      external_sink_gate_pin <= gpio_next;
      ports_enable <= running && !safe_now;
      legacy_sink_only <= safe_now && on_vbus;
      active_cfg <= cfg_now;
      unique_address <= {bscl_pkg::ADDR_UPPER, addr_reg, 1'b0};
      boot_done <= running;
      cfg_loaded <= loaded_reg;
      slow_clock_select <= running && low_power_req;
      flash_clk <= sck_reg;
      flash_cs_n <= cs_n_reg;
      flash_data_out <= mosi_reg;
      load_data <= rx_reg;
      load_valid <= valid_reg;
    end
  end

endmodule : bscl_loader

// File: rtl/bscl_pkg.sv
// Package: constants and types for the boot strap configuration loader
package bscl_pkg;
  // Strap ratio is an 8-bit ADC code scaled so 1.00 = 100 (hundredths)
  localparam int unsigned RATIO_W = 8;
  // Core clock rate and SPI clock rate
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SCK_HZ = 12000000;
  // Half SCK period in core cycles, rounded up so the rate never exceeds the 12 MHz target
  localparam int unsigned SCK_HALF_RAW = (CLK_HZ + 2 * SCK_HZ - 1) / (2 * SCK_HZ);
  localparam logic [3:0] SCK_HALF = (SCK_HALF_RAW < 1) ? 4'h1 : 4'(SCK_HALF_RAW);
  // Flash read command and start address
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [23:0] FLASH_START_ADDR = 24'h000000;
  // Address field fixed upper bits
  localparam logic [3:0] ADDR_UPPER = 4'h4;
  // Address decode values
  localparam logic [2:0] ADDR_GND = 3'h0;
  localparam logic [2:0] ADDR_LOW = 3'h1;
  localparam logic [2:0] ADDR_MID = 3'h2;
  localparam logic [2:0] ADDR_HIGH = 3'h3;
  // Ratio thresholds in hundredths
  localparam logic [7:0] T10 = 8'h0A;
  localparam logic [7:0] T19 = 8'h13;
  localparam logic [7:0] T29 = 8'h1D;
  localparam logic [7:0] T39 = 8'h27;
  localparam logic [7:0] T49 = 8'h31;
  localparam logic [7:0] T59 = 8'h3B;
  localparam logic [7:0] T69 = 8'h45;
  localparam logic [7:0] T89 = 8'h59;

  // Dead-battery modes
  typedef enum logic [2:0] {
    BSCL_DB_NO_RESPONSE,
    BSCL_DB_WAIT_INT,
    BSCL_DB_WAIT_EXT,
    BSCL_DB_RETRY_INT,
    BSCL_DB_RETRY_EXT,
    BSCL_DB_NO_WAIT
  } bscl_db_t;

  // Fallback configurations
  typedef enum logic [3:0] {
    BSCL_CFG_SAFE,
    BSCL_CFG_INF_WAIT,
    BSCL_CFG_1,
    BSCL_CFG_2,
    BSCL_CFG_3,
    BSCL_CFG_4,
    BSCL_CFG_5,
    BSCL_CFG_RESERVED
  } bscl_cfg_t;
endpackage : bscl_pkg

// File: verification/bscl_flash_model.sv
// Behavioural serial flash that also holds the boot strap level on its data line
`timescale 1ns/10ps
module bscl_flash_model (
  // Serial bus from the loader
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  // Data back to the loader and strap level
  output logic miso,
  input wire logic strap_high
);
  logic [7:0] mem [0:15];
  logic [31:0] cmd = 32'h0;
  logic dout = 1'b0;
  logic drv = 1'b0;
  int bit_cnt = 0;
  int tx_cnt = 0;
  int k;
  // New frame on chip select falling
  always @(negedge cs_n) begin
    bit_cnt = 0;
    drv = 1'b0;
    tx_cnt++;
  end
  // Command bits sampled on the rising clock
  always @(posedge sck) begin
    if (!cs_n) begin
      if (bit_cnt < 32) cmd = {cmd[30:0], mosi};
      bit_cnt++;
    end
  end
  // Read data shifted out on the falling clock, MSB first
  always @(negedge sck) begin
    if (!cs_n && bit_cnt >= 32) begin
      k = bit_cnt - 32;
      dout = mem[(k / 8) % 16][7 - k % 8];
      drv = 1'b1;
    end
  end
  // Released line falls back to the strap resistor level
  assign miso = (cs_n || !drv) ? strap_high : dout;
endmodule : bscl_flash_model

// File: verification/bscl_loader_checker.sv
// Port checks for the boot strap configuration loader
`timescale 1ns/10ps
module bscl_loader_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Supply and flash pins
  input wire logic main_supply_input,
  input wire logic flash_data_out,
  input wire logic flash_clk,
  input wire logic flash_cs_n,
  // Boot status and decode
  input wire logic boot_done,
  input wire logic cfg_loaded,
  input wire logic [7:0] unique_address,
  input bscl_pkg::bscl_db_t db_mode,
  input bscl_pkg::bscl_cfg_t active_cfg,
  // Switch and port controls
  input wire logic high_voltage_path_first,
  input wire logic external_sink_gate_pin,
  input wire logic ports_enable
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // Serial bus framing
  a_cs_clk_idle: assert property (flash_cs_n |-> !flash_clk) else $error("clock not idle low");
  a_first_bit: assert property ($fell(flash_cs_n) |-> !flash_clk && !flash_data_out ##[1:2]
    flash_clk) else $error("first bit not with select");
  a_data_on_fall: assert property (!flash_cs_n && !$past(flash_cs_n) && $changed(flash_data_out)
    |-> $fell(flash_clk)) else $error("data moved off falling clock");
  a_clk_half: assert property ($rose(flash_clk) |=> flash_clk ##1 !flash_clk)
    else $error("clock high too long");
  // Dead battery behaviour
  a_nr_wait_idle: assert property (db_mode inside {bscl_pkg::BSCL_DB_NO_RESPONSE,
    bscl_pkg::BSCL_DB_WAIT_INT, bscl_pkg::BSCL_DB_WAIT_EXT} && !main_supply_input
    && !$past(main_supply_input, 4) |-> flash_cs_n) else $error("load without supply");
  a_nr_switch_off: assert property (db_mode == bscl_pkg::BSCL_DB_NO_RESPONSE && !boot_done
    |-> !high_voltage_path_first && !external_sink_gate_pin) else $error("switch on");
  a_ext_gate_mode: assert property (external_sink_gate_pin && !boot_done && !cfg_loaded
    |-> db_mode inside {bscl_pkg::BSCL_DB_WAIT_EXT, bscl_pkg::BSCL_DB_RETRY_EXT})
    else $error("external gate in wrong mode");
  a_int_path_mode: assert property (high_voltage_path_first && !boot_done && !cfg_loaded
    |-> db_mode inside {bscl_pkg::BSCL_DB_WAIT_INT, bscl_pkg::BSCL_DB_RETRY_INT})
    else $error("internal path in wrong mode");
  a_retry_no_fb: assert property (boot_done && db_mode inside {bscl_pkg::BSCL_DB_RETRY_INT,
    bscl_pkg::BSCL_DB_RETRY_EXT} |-> cfg_loaded) else $error("retry mode gave up");
  // Fallback use and address format
  a_loaded_no_fb: assert property (cfg_loaded |-> active_cfg == bscl_pkg::BSCL_CFG_RESERVED)
    else $error("fallback used after load");
  a_safe_ports: assert property (boot_done && active_cfg == bscl_pkg::BSCL_CFG_SAFE
    |-> !ports_enable) else $error("ports on in safe");
  a_addr_fixed: assert property (boot_done |-> unique_address[7:4] == 4'h4
    && !unique_address[0]) else $error("address upper bits wrong");
endmodule : bscl_loader_checker

bind bscl_loader bscl_loader_checker bscl_loader_checker_inst (.clock, .srst,
  .main_supply_input, .flash_data_out, .flash_clk, .flash_cs_n, .boot_done, .cfg_loaded,
  .unique_address, .db_mode, .active_cfg, .high_voltage_path_first, .external_sink_gate_pin,
  .ports_enable);

// File: verification/bscl_loader_tb_top.sv
// Self-checking testbench for the boot strap configuration loader
`timescale 1ns/10ps
module bscl_loader_tb_top;
  localparam int unsigned LB = 4;
  localparam int unsigned TRIES = 4;
  // Design inputs
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] address_strap_input = 8'h00;
  logic [7:0] boot_strap_input = 8'h00;
  logic strap_valid = 1'b1;
  logic main_supply_input = 1'b0;
  logic vbus_present = 1'b1;
  logic low_power_req = 1'b0;
  logic strap_high = 1'b1;
  // Design outputs
  logic flash_data_in, flash_data_out, flash_clk, flash_cs_n, load_valid, boot_done;
  logic cfg_loaded, high_voltage_path_first, external_sink_gate_pin, ports_enable;
  logic legacy_sink_only, slow_clock_select;
  logic [7:0] load_data, unique_address;
  bscl_pkg::bscl_db_t db_mode;
  bscl_pkg::bscl_cfg_t fallback_cfg, active_cfg;
  // Bench state; mode and config codes follow the package enum order
  int error_cnt = 0;
  int checks = 0;
  logic [31:0] seed = 32'h83B3313D;
  logic [7:0] rx_q [$];
  int hr [15] = '{10, 25, 35, 45, 55, 80, 15, 25, 35, 45, 55, 65, 75, 85, 95};
  int ar [4] = '{5, 30, 50, 98};
  int hi_m [11] = '{0, 0, 1, 3, 2, 4, 5, 5, 5, 5, 5};
  int hi_c [11] = '{0, 0, 0, 1, 0, 1, 0, 0, 0, 0, 0};
  int lo_m [11] = '{0, 0, 0, 3, 5, 4, 0, 5, 0, 5, 5};
  int lo_c [11] = '{7, 2, 3, 1, 4, 1, 5, 7, 7, 6, 6};
  ////////////////////////////////////////
  always #12.5 clock = ~clock;
  bscl_loader #(.LOAD_BYTES(LB), .MAX_TRIES(TRIES)) bscl_loader_inst (.clock, .srst,
    .address_strap_input, .boot_strap_input, .strap_valid, .main_supply_input, .vbus_present,
    .low_power_req, .flash_data_in, .flash_data_out, .flash_clk, .flash_cs_n, .load_data,
    .load_valid, .boot_done, .cfg_loaded, .unique_address, .db_mode, .fallback_cfg,
    .active_cfg, .high_voltage_path_first, .external_sink_gate_pin, .ports_enable,
    .legacy_sink_only, .slow_clock_select);
  bscl_flash_model bscl_flash_model_inst (.sck(flash_clk), .cs_n(flash_cs_n),
    .mosi(flash_data_out), .miso(flash_data_in), .strap_high(strap_high));
  // Collect loaded bytes
  always @(negedge clock) if (load_valid === 1'b1) rx_q.push_back(load_data);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      error_cnt++;
    end
  endtask : check
  // Reset with new straps; strap pin level comes through the idle flash line
  task automatic boot(input logic pin, input int r, input int a, input logic sup);
    @(negedge clock);
    srst = 1'b1;
    strap_high = pin;
    boot_strap_input = 8'(r);
    address_strap_input = 8'(a);
    main_supply_input = sup;
    repeat (5) @(negedge clock);
    srst = 1'b0;
    bscl_flash_model_inst.tx_cnt = 0;
    rx_q.delete();
  endtask : boot
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (boot_done !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
    check("boot_done", boot_done, 1);
  endtask : wait_done
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Watchdog against a hung boot
  initial begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    wrap_up();
  end
  initial begin
    int r, a, m;
    logic [2:0] ea;
    for (int i = 0; i < 15; i++) begin
      r = hr[i] + int'(xs() % 3) - 1;
      a = ar[i % 4] + int'(xs() % 3) - 1;
      ea = a < 19 ? 3'h0 : a < 39 ? 3'h1 : a < 59 ? 3'h2 : 3'h3;
      boot(i < 6, r, a, 1'b0);
      repeat (12) @(negedge clock);
      m = i < 6 ? hi_m[r / 10] : lo_m[r / 10];
      check("db_mode", db_mode, m);
      check("fallback", fallback_cfg, i < 6 ? hi_c[r / 10] : lo_c[r / 10]);
      check("address", unique_address, {4'h4, ea, 1'b0});
      check("int_path", high_voltage_path_first, m == 1 || m == 3);
      check("ext_gate", external_sink_gate_pin, m == 2 || m == 4);
    end
    $display("test strap decode done");
    foreach (bscl_flash_model_inst.mem[k]) bscl_flash_model_inst.mem[k] = 8'(xs());
    bscl_flash_model_inst.mem[0] = {1'b0, 7'(xs()) | 7'h01};
    boot(1'b1, 80, 30, 1'b0);
    wait_done(2000);
    check("cfg_loaded", cfg_loaded, 1);
    check("flash_cmd", bscl_flash_model_inst.cmd, 32'h03000000);
    check("frames", bscl_flash_model_inst.tx_cnt, 1);
    check("byte_count", rx_q.size(), LB);
    foreach (rx_q[k]) check("load_data", rx_q[k], bscl_flash_model_inst.mem[k]);
    check("active_cfg", active_cfg, 7);
    $display("test flash load done");
    bscl_flash_model_inst.mem[0] = 8'h00;
    boot(1'b1, 35, 30, 1'b0);
    repeat (3000) @(negedge clock);
    check("boot_done", boot_done, 0);
    check("retries", bscl_flash_model_inst.tx_cnt > TRIES, 1);
    $display("test endless retry done");
    bscl_flash_model_inst.mem[0] = 8'hFF;
    boot(1'b1, 80, 30, 1'b0);
    wait_done(3000);
    check("tries", bscl_flash_model_inst.tx_cnt, TRIES);
    check("active_cfg", active_cfg, 0);
    check("ports", ports_enable, 0);
    check("legacy", legacy_sink_only, 1);
    $display("test safe fallback done");
    bscl_flash_model_inst.mem[0] = 8'h5A;
    boot(1'b1, 10, 30, 1'b0);
    repeat (400) @(negedge clock);
    check("frames", bscl_flash_model_inst.tx_cnt, 0);
    main_supply_input = 1'b1;
    wait_done(2000);
    check("cfg_loaded", cfg_loaded, 1);
    boot_strap_input = 8'h37;
    low_power_req = 1'b1;
    repeat (4) @(negedge clock);
    check("db_mode", db_mode, 0);
    check("slow_clock", slow_clock_select, 1);
    low_power_req = 1'b0;
    repeat (4) @(negedge clock);
    check("slow_clock", slow_clock_select, 0);
    $display("test supply wait done");
    wrap_up();
  end
endmodule : bscl_loader_tb_top
